// ### rtl/dpram_core.sv
// dual-port synchronous ram: two identical registered ports over one shared array
`timescale 1ns/1ns
module dpram_core
	import dpram_pkg::*;
(
	// clock, reset, enable
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	// left port pins
	input  wire logic              left_port_clk,
	input  wire logic [ADDR_W-1:0] left_addr,
	input  wire logic [DATA_W-1:0] left_data_pins_in,
	input  wire logic              left_sel_n,
	input  wire logic              left_wr_n,
	input  wire logic              left_input_register_hold_n,
	input  wire logic              left_oe_n,
	output logic      [DATA_W-1:0] left_data_pins_out,
	output logic                   left_data_pins_oe,
	output logic                   left_standby,
	// right port pins
	input  wire logic              right_port_clk,
	input  wire logic [ADDR_W-1:0] right_addr,
	input  wire logic [DATA_W-1:0] right_data_pins_in,
	input  wire logic              right_sel_n,
	input  wire logic              right_wr_n,
	input  wire logic              right_input_register_hold_n,
	input  wire logic              right_oe_n,
	output logic      [DATA_W-1:0] right_data_pins_out,
	output logic                   right_data_pins_oe,
	output logic                   right_standby
);
	localparam int PIN_W = 1 + ADDR_W + DATA_W + 4;

	// shared storage, no reset: contents are undefined at power-up
	logic [DATA_W-1:0] mem_reg [DEPTH];

	logic [PIN_W-1:0]  pins_raw  [NUM_PORTS];
	logic [PIN_W-1:0]  pins_s    [NUM_PORTS];
	logic              clk_s     [NUM_PORTS];
	logic              clk_d_reg [NUM_PORTS];
	logic              rise      [NUM_PORTS];
	logic [ADDR_W-1:0] addr_s    [NUM_PORTS];
	logic [DATA_W-1:0] din_s     [NUM_PORTS];
	logic              sel_n_s   [NUM_PORTS];
	logic              wr_n_s    [NUM_PORTS];
	logic              hold_n_s  [NUM_PORTS];
	logic              oe_n_s    [NUM_PORTS];

	logic [ADDR_W-1:0] addr_reg  [NUM_PORTS];
	logic [DATA_W-1:0] din_reg   [NUM_PORTS];
	port_mode_e        mode_reg  [NUM_PORTS];
	logic              wr_go_reg [NUM_PORTS];
	logic [DATA_W-1:0] dout_reg  [NUM_PORTS];
	logic              doe_reg   [NUM_PORTS];
	logic              standby_reg [NUM_PORTS];

	// gather both ports' pins so that one body serves left and right
	assign pins_raw[PORT_L] = {left_port_clk, left_addr, left_data_pins_in, left_sel_n,
		left_wr_n, left_input_register_hold_n, left_oe_n};
	assign pins_raw[PORT_R] = {right_port_clk, right_addr, right_data_pins_in, right_sel_n,
		right_wr_n, right_input_register_hold_n, right_oe_n};

	assign left_data_pins_out  = dout_reg[PORT_L];
	assign left_data_pins_oe   = doe_reg[PORT_L];
	assign left_standby        = standby_reg[PORT_L];
	assign right_data_pins_out = dout_reg[PORT_R];
	assign right_data_pins_oe  = doe_reg[PORT_R];
	assign right_standby       = standby_reg[PORT_R];

	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		// every pin crosses from the port's own timing into ref_clk
		pin_sync #(.W(PIN_W)) u_sync (
			.ref_clk  (ref_clk),
			.rst_n    (rst_n),
			.clk_en   (clk_en),
			.pin_in   (pins_raw[p]),
			.sync_out (pins_s[p])
		);

		// clock and data pass equal stages, so data seen at rise matches the pin edge
		assign {clk_s[p], addr_s[p], din_s[p], sel_n_s[p], wr_n_s[p], hold_n_s[p],
			oe_n_s[p]} = pins_s[p];
		assign rise[p] = clk_s[p] && !clk_d_reg[p];

		// port clock edge detector
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
				clk_d_reg[p] <= 1'b0;
			else if (clk_en)
				clk_d_reg[p] <= clk_s[p];
		end

		// address and data-in registers, stalled while hold is high
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
			begin
				addr_reg[p] <= '0;
				din_reg[p]  <= '0;
			end
			else if (clk_en && rise[p] && !hold_n_s[p])
			begin
				addr_reg[p] <= addr_s[p];
				din_reg[p]  <= din_s[p];
			end
		end

		// control registers: mode is decided at every port edge, hold does not stall it
		// standby has its own flop so the pin carries no decode glitches
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
			begin
				mode_reg[p]    <= MODE_STANDBY;
				standby_reg[p] <= 1'b1;
			end
			else if (clk_en && rise[p])
			begin
				standby_reg[p] <= sel_n_s[p];
				if (is_write(sel_n_s[p], wr_n_s[p]))
					mode_reg[p] <= MODE_WRITE;
				else if (is_read(sel_n_s[p], wr_n_s[p]))
					mode_reg[p] <= MODE_READ;
				else
					mode_reg[p] <= MODE_STANDBY;
			end
		end

		// write cycle lasts from its starting edge to the next; the array takes it once
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
				wr_go_reg[p] <= 1'b0;
			else if (clk_en)
				wr_go_reg[p] <= rise[p] && is_write(sel_n_s[p], wr_n_s[p]);
		end

		// flow-through read: array word follows the registered address every cycle while the mode is MODE_READ
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
				dout_reg[p] <= '0;
			else if (clk_en && mode_reg[p] == MODE_READ)
				dout_reg[p] <= mem_reg[addr_reg[p]];
		end

		// drive only in a read with enable low; a write ignores the enable
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
				doe_reg[p] <= 1'b0;
			else if (clk_en)
				doe_reg[p] <= (mode_reg[p] == MODE_READ) && !oe_n_s[p];
		end

		// enable is only resampled, not clocked by the port, so it acts between edges
		AST_OE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && oe_n_s[p] |=> !doe_reg[p])
			else $error("outputs driven while output enable is high");

		AST_DESELECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && rise[p] && sel_n_s[p] |=> (mode_reg[p] == MODE_STANDBY) ##1 !doe_reg[p])
			else $error("port not deselected after select high");

		// the pins go quiet one cycle after the mode, as the enable flop follows the mode
		AST_STANDBY: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && rise[p] && !sel_n_s[p] |=> !standby_reg[p] &&
				mode_reg[p] != MODE_STANDBY)
			else $error("selected port stayed in standby");

		AST_NO_LOAD_OFF_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
			!rise[p] |=> $stable(addr_reg[p]) && $stable(din_reg[p]))
			else $error("input register changed without a port clock rise");

		AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
			rise[p] && hold_n_s[p] |=> $stable(addr_reg[p]) && $stable(din_reg[p]))
			else $error("input registers changed while held");

		AST_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && rise[p] && !hold_n_s[p] |=> addr_reg[p] == $past(addr_s[p]) &&
				din_reg[p] == $past(din_s[p]))
			else $error("input registers did not load");

		AST_WRITE_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && rise[p] && !sel_n_s[p] && !wr_n_s[p] |=>
				wr_go_reg[p] && mode_reg[p] == MODE_WRITE ##1 !doe_reg[p])
			else $error("write cycle did not start");

		AST_WRITE_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && rise[p] && mode_reg[p] == MODE_WRITE && wr_n_s[p] |=>
				mode_reg[p] != MODE_WRITE && !wr_go_reg[p])
			else $error("write cycle did not end at next edge");

		AST_READ_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
			clk_en && rise[p] && !sel_n_s[p] && wr_n_s[p] ##1 clk_en && !oe_n_s[p] |=>
				doe_reg[p])
			else $error("read did not drive data pins");
	end

	// shared array; on a same-address collision the right port is written last and wins
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				if (wr_go_reg[p])
					mem_reg[addr_reg[p]] <= din_reg[p];
			end
		end
	end

	AST_MEM_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wr_go_reg[PORT_R] |=> mem_reg[$past(addr_reg[PORT_R])] == $past(din_reg[PORT_R]))
		else $error("array word not written");

	// left write is only checked when the right port does not hit the same word
	AST_MEM_WRITE_L: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wr_go_reg[PORT_L] &&
			!(wr_go_reg[PORT_R] && addr_reg[PORT_R] == addr_reg[PORT_L]) |=>
			mem_reg[$past(addr_reg[PORT_L])] == $past(din_reg[PORT_L]))
		else $error("left array word not written");

	// a reader parked on a word sees the other port's write two cycles later
	AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wr_go_reg[PORT_R] && mode_reg[PORT_L] == MODE_READ && !rise[PORT_L] &&
			addr_reg[PORT_L] == addr_reg[PORT_R] ##1 clk_en |=>
			dout_reg[PORT_L] == $past(din_reg[PORT_R], 2))
		else $error("reader does not see the other port's write");
endmodule

// ### rtl/dpram_pkg.sv
// constants, enums and decode functions shared by the dual-port ram port logic
package dpram_pkg;
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 9;
	localparam int DEPTH     = 4096;
	localparam int NUM_PORTS = 2;
	localparam int PORT_L    = 0;
	localparam int PORT_R    = 1;

	// mode of a port decided at each port clock rise
	typedef enum logic [1:0] {
		MODE_STANDBY,
		MODE_WRITE,
		MODE_READ
	} port_mode_e;

	// both selects are active low
	function automatic logic is_write(input logic sel_n, input logic wr_n);
		return !sel_n && !wr_n;
	endfunction

	function automatic logic is_read(input logic sel_n, input logic wr_n);
		return !sel_n && wr_n;
	endfunction
endpackage

// ### rtl/pin_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	// clock and control
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	// pin side and synchronised side
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else if (clk_en)
		begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ### verification/port_host.sv
// host model that runs whole port clock cycles on one ram port
`timescale 1ns/1ns
module port_host
	import dpram_pkg::*;
(
	// system clock
	input  wire logic         ref_clk,
	// pins toward the ram port
	output logic              port_clk,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] din,
	output logic              sel_n,
	output logic              wr_n,
	output logic              hold_n,
	output logic              oe_n
);
	// idle deselected; hold low so the first rise loads the registers
	initial
	begin
		port_clk = 1'b0;
		addr = 12'h000;
		din = 9'h000;
		sel_n = 1'b1;
		wr_n = 1'b1;
		hold_n = 1'b0;
		oe_n = 1'b0;
	end

	// pins set a cycle ahead of the rise and held three cycles past it
	task automatic op(input logic s, input logic w, input logic h,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		#1;
		sel_n = s;
		wr_n = w;
		hold_n = h;
		addr = a;
		din = d;
		@(posedge ref_clk);
		#1;
		port_clk = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		port_clk = 1'b0;
		din = ~din; // bus released, stale value must not linger
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// a write right after a read with outputs on may store the read data; write twice
	task automatic write_after_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		op(1'b0, 1'b0, 1'b0, a, d);
		op(1'b0, 1'b0, 1'b0, a, d);
	endtask

	// drives oe_n to the given value after the next ref_clk rise
	task automatic set_oe(input logic v);
		@(posedge ref_clk);
		#1;
		oe_n = v;
	endtask
endmodule

// ### verification/dpram_core_tb.sv
// self-checking bench for the dual-port ram port logic
`timescale 1ns/1ns
`define CHK(nm, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("wrong value %s exp %h got %h", nm, e, g); \
		end \
	end
module dpram_core_tb
	import dpram_pkg::*;
;
	logic              ref_clk, rst_n, l_clk, r_clk, l_s, r_s, l_w, r_w;
	logic              l_h, r_h, l_oe_n, r_oe_n, l_oe, r_oe, l_sb, r_sb;
	logic [ADDR_W-1:0] l_a, r_a;
	logic [DATA_W-1:0] l_d, r_d, l_out, r_out;
	wire  [DATA_W-1:0] l_in = l_oe ? l_out : l_d;
	wire  [DATA_W-1:0] r_in = r_oe ? r_out : r_d;
	int                bad_count = 0;
	int                cmp_count = 0;
	int                cycles = 0;

	// design and one host per port
	dpram_core i_dpram_core (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
		.left_port_clk(l_clk), .left_addr(l_a), .left_data_pins_in(l_in),
		.left_sel_n(l_s), .left_wr_n(l_w), .left_input_register_hold_n(l_h),
		.left_oe_n(l_oe_n), .left_data_pins_out(l_out), .left_data_pins_oe(l_oe),
		.left_standby(l_sb), .right_port_clk(r_clk), .right_addr(r_a),
		.right_data_pins_in(r_in), .right_sel_n(r_s), .right_wr_n(r_w),
		.right_input_register_hold_n(r_h), .right_oe_n(r_oe_n),
		.right_data_pins_out(r_out), .right_data_pins_oe(r_oe), .right_standby(r_sb));
	port_host i_port_host_l (.ref_clk(ref_clk), .port_clk(l_clk), .addr(l_a), .din(l_d),
		.sel_n(l_s), .wr_n(l_w), .hold_n(l_h), .oe_n(l_oe_n));
	port_host i_port_host_r (.ref_clk(ref_clk), .port_clk(r_clk), .addr(r_a), .din(r_d),
		.sel_n(r_s), .wr_n(r_w), .hold_n(r_h), .oe_n(r_oe_n));

	// 100 ns system clock
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard, well past the roughly 150 cycles the tests need
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			bad_count++;
			end_sim();
		end
	end

	// words cross between ports, ninth bit included; write turns outputs off
	task automatic t_cross();
		i_port_host_l.op(0, 0, 0, 12'hfff, 9'h1ff);
		i_port_host_l.op(0, 1, 0, 12'hfff, 9'h000);
		`CHK("l_out", 9'h1ff, l_out)
		`CHK("l_oe", 1'b1, l_oe)
		i_port_host_l.write_after_read(12'h000, 9'h0a5);
		`CHK("l_oe", 1'b0, l_oe)
		i_port_host_r.op(0, 1, 0, 12'hfff, 9'h000);
		`CHK("r_out", 9'h1ff, r_out)
		`CHK("r_oe", 1'b1, r_oe)
		`CHK("r_sb", 1'b0, r_sb)
		i_port_host_r.write_after_read(12'h800, 9'h123);
		i_port_host_l.op(0, 1, 0, 12'h800, 9'h000);
		`CHK("l_out", 9'h123, l_out)
		i_port_host_r.op(0, 1, 0, 12'h000, 9'h000);
		`CHK("r_out", 9'h0a5, r_out)
		i_port_host_r.write_after_read(12'h800, 9'h0e7);
		`CHK("l_out", 9'h0e7, l_out)
		$display("test cross done");
	endtask

	// deselect powers the port down and floats the pins
	task automatic t_desel();
		i_port_host_l.op(1, 1, 0, 12'hfff, 9'h000);
		`CHK("l_sb", 1'b1, l_sb)
		`CHK("l_oe", 1'b0, l_oe)
		$display("test deselect done");
	endtask

	// output enable floats a read without a port edge; write ignores it
	task automatic t_oe();
		i_port_host_l.op(0, 1, 0, 12'hfff, 9'h000);
		`CHK("l_oe", 1'b1, l_oe)
		i_port_host_l.set_oe(1'b1);
		repeat (4) @(posedge ref_clk);
		#1;
		`CHK("l_oe", 1'b0, l_oe)
		i_port_host_l.op(0, 0, 0, 12'h004, 9'h0c3);
		i_port_host_l.set_oe(1'b0);
		i_port_host_l.op(0, 1, 0, 12'h004, 9'h000);
		`CHK("l_out", 9'h0c3, l_out)
		$display("test enable done");
	endtask

	// hold high keeps the old address although the pins moved
	task automatic t_hold();
		i_port_host_l.op(0, 1, 1, 12'h800, 9'h000);
		`CHK("l_out", 9'h0c3, l_out)
		`CHK("l_oe", 1'b1, l_oe)
		$display("test hold done");
	endtask

	// reset, then every scenario in turn
	initial
	begin
		rst_n = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		t_cross();
		t_desel();
		t_oe();
		t_hold();
		end_sim();
	end
endmodule
